//--- fifo_rd_defs.vh
`ifndef FIFO_RD_DEFS_VH
`define FIFO_RD_DEFS_VH

// data path widths
`define DATA_W          18
`define OFFSET_W        12
`define SUM_W           15

// smallest variant and its offset defaults
`define DEF_DEPTH       256
`define DEF_ADDR_W      8
`define DEF_OFFSET      12'h01F

// offset register sequence
`define SEL_EMPTY_OFF   2'h1
`define SEL_FULL_OFF    2'h2

// cycles after reset release before the straps are taken
`define STRAP_WAIT      2'h3

// reset values
`define DOUT_RST        18'h00000

`endif

//--- pin_sync.v
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             sys_clk_i,
  input  wire             nrst_i,
  input  wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o,
  output wire [WIDTH-1:0] rise_o
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  reg [WIDTH-1:0] last_r;

  ////////////////////////////////////////////////////////////////////////
  // two flops against metastability, a third only for edge detection
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
      last_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign q_o    = sync_r;
  assign rise_o = sync_r & ~last_r; // edge seen only past the second flop

endmodule // pin_sync

`default_nettype wire

//--- fifo_read_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "fifo_rd_defs.vh"

// What this block does
// [RULE1] read enable low and data present: each read edge loads next word to output
// [RULE2] read enable high: output register and data outputs hold their word
// [RULE3] standard mode: reader must request every word, the first included
// [RULE4] standard empty flag falls after last read, blocks reads, rises after write
// [RULE5] fall-through: first word reaches outputs on third read edge after write
// [RULE6] fall-through: output-ready falls together with the first valid word
// [RULE7] fall-through: output-ready rises only on true read; last word stays shown
// [RULE8] output enable low drives the output register; high floats the bus
// [RULE9] two 12-bit offset registers, loaded from inputs, readable on outputs
// [RULE10] load and write low: writes go empty offset, full offset, then wrap
// [RULE11] offset write pointer kept while load high; next load write continues
// [RULE12] load low with write enable high does nothing; load high writes FIFO
// [RULE13] load and read low: own read pointer returns offsets in the same order
// [RULE14] offset read-back only in standard mode, suppressed in fall-through
// [RULE15] outside logic never reads and writes offsets at the same time
// [RULE16] outside logic sets unprogrammed offset bits to zero
// [RULE17] daisy chain: first-load strap low on first device, expansion pins chained; here the strap only picks partial flag timing, no chaining
// [RULE18] standard full flag low when full after depth writes, blocking writes
// [RULE19] fall-through input-ready high when full, capacity is depth plus one
// [RULE20] full flag changes on write edges, empty flag on read edges only
// [RULE21] standard almost-full falls after depth minus m writes
// [RULE22] fall-through almost-full falls one write later than standard
// [RULE23] async: almost-full set on write edge, cleared on read edge; sync: write only
// [RULE24] straps latched at reset choose timing mode and partial flag timing
// [RULE25] write enable low stores a word each write edge unless full
// [RULE26] reset clears pointers and output register, offsets take defaults
module fifo_read_ctrl #(
  parameter DEPTH   = `DEF_DEPTH,
  parameter ADDR_W  = `DEF_ADDR_W,
  parameter [`OFFSET_W-1:0] OFF_DEF = `DEF_OFFSET
) (
  input  wire                 sys_clk_i,
  input  wire                 nrst_i,
  input  wire                 wr_clk_i,
  input  wire                 rd_clk_i,
  input  wire                 write_enable_n_i,
  input  wire                 read_enable_n_i,
  input  wire                 offset_load_n_i,
  input  wire                 output_enable_n_i,
  input  wire                 first_load_strap_n_i,
  input  wire                 write_expansion_in_n_i,
  input  wire                 read_expansion_in_n_i,
  input  wire [`DATA_W-1:0]   data_in_i,
  output wire [`DATA_W-1:0]   data_out_o,
  output wire                 data_out_oe_o,
  output wire                 full_flag_n_o,
  output wire                 empty_flag_n_o,
  output wire                 almost_full_flag_n_o
);

  localparam CW = ADDR_W + 1;
  localparam TW = ADDR_W + 2;
  localparam [`SUM_W-1:0] CAP_STD  = DEPTH[`SUM_W-1:0];
  localparam [`SUM_W-1:0] CAP_FALL_THROUGH_MODE = CAP_STD + {{(`SUM_W-1){1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire       wclk_rise;
  wire       rclk_rise;
  wire [6:0] ctl_s;
  wire [`DATA_W-1:0] din_s;

  // both clock pins pass two flops, their rising edges become events
  pin_sync #(.WIDTH(2)) u_clk_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .d_i       ({rd_clk_i, wr_clk_i}),
    .q_o       (),
    .rise_o    ({rclk_rise, wclk_rise})
  );

  // control and strap pins, same latency as the clock edges
  pin_sync #(.WIDTH(7)) u_ctl_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .d_i       ({read_expansion_in_n_i, write_expansion_in_n_i,
                 first_load_strap_n_i, output_enable_n_i,
                 offset_load_n_i, read_enable_n_i, write_enable_n_i}),
    .q_o       (ctl_s),
    .rise_o    ()
  );

  // data follows the same two-flop path so it lines up with its edge
  pin_sync #(.WIDTH(`DATA_W)) u_din_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .d_i       (data_in_i),
    .q_o       (din_s),
    .rise_o    ()
  );

  wire wen_n   = ctl_s[0];
  wire ren_n   = ctl_s[1];
  wire ld_n    = ctl_s[2];
  wire oe_n    = ctl_s[3];
  wire fl_n    = ctl_s[4];
  wire wxi_n   = ctl_s[5];
  wire rxi_n   = ctl_s[6];

  ////////////////////////////////////////////////////////////////////////
  // strap capture

  reg [1:0] strap_cnt_r;
  reg       fall_through_mode_r;
  reg       sync_paf_r;
  wire      strap_take = (strap_cnt_r == `STRAP_WAIT - 2'h1);
  wire      running    = (strap_cnt_r == `STRAP_WAIT);

  // straps sampled through the synchroniser once it has filled after release
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_cnt_r <= 2'h0;
      fall_through_mode_r      <= 1'b0;
      sync_paf_r  <= 1'b0;
    end else if (!running) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_take) begin
        fall_through_mode_r     <= wxi_n & ~rxi_n; // [RULE24]
        sync_paf_r <= fl_n;           // [RULE24]
      end
    end
  end

  // the first-load strap only picks the partial flag timing; it marks no daisy-chain position
  wire wr_edge = running & wclk_rise;
  wire rd_edge = running & rclk_rise;

  ////////////////////////////////////////////////////////////////////////
  // storage and pointers

  reg [`DATA_W-1:0] mem [0:DEPTH-1];
  reg [CW-1:0]      wr_ptr_r;
  reg [CW-1:0]      rd_ptr_r;
  reg [CW-1:0]      wr_vis1_r;
  reg [CW-1:0]      wr_vis2_r;
  reg               out_valid_r;

  wire [CW-1:0] mem_cnt   = wr_ptr_r - rd_ptr_r;
  wire          mem_full  = (mem_cnt == DEPTH[CW-1:0]);
  wire [TW-1:0] total_cnt = {1'b0, mem_cnt} + {{(TW-1){1'b0}}, fall_through_mode_r & out_valid_r};
  wire [`SUM_W-1:0] total_w = {{(`SUM_W-TW){1'b0}}, total_cnt};

  // read side only sees writes two read edges late, giving the fall-through
  // first word on the third edge; it also hides write-side jitter
  wire          rd_empty  = (wr_vis2_r == rd_ptr_r);

  ////////////////////////////////////////////////////////////////////////
  // offset registers

  reg [`OFFSET_W-1:0] ae_thresh_r;
  reg [`OFFSET_W-1:0] af_thresh_r;
  reg [1:0]           off_wsel_r;
  reg [1:0]           off_rsel_r;
  reg                 full_n_r;

  wire off_wr = wr_edge & ~ld_n & ~wen_n;           // [RULE12]
  wire off_rd = rd_edge & ~ld_n & ~ren_n & ~fall_through_mode_r; // [RULE14]
  wire fifo_wr = wr_edge & ld_n & ~wen_n & ~mem_full &
                 (fall_through_mode_r ? ~full_n_r : full_n_r);    // [RULE25]

  // writes alternate empty then full offset; pointer survives load high
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ae_thresh_r <= OFF_DEF; // [RULE26]
      af_thresh_r <= OFF_DEF; // [RULE26]
      off_wsel_r  <= `SEL_EMPTY_OFF;
    end else if (off_wr) begin
      if (off_wsel_r == `SEL_FULL_OFF) begin
        af_thresh_r <= din_s[`OFFSET_W-1:0]; // [RULE9]
        off_wsel_r  <= `SEL_EMPTY_OFF;       // [RULE10]
      end else begin
        ae_thresh_r <= din_s[`OFFSET_W-1:0]; // [RULE9]
        off_wsel_r  <= `SEL_FULL_OFF;        // [RULE11]
      end
    end
  end

  // read-back has its own pointer; a clash with a write is the user's fault
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      off_rsel_r <= `SEL_EMPTY_OFF;
    end else if (off_rd) begin
      case (off_rsel_r)
        `SEL_EMPTY_OFF: off_rsel_r <= `SEL_FULL_OFF;  // [RULE13]
        `SEL_FULL_OFF:  off_rsel_r <= `SEL_EMPTY_OFF; // [RULE13]
        default:        off_rsel_r <= `SEL_EMPTY_OFF;
      endcase
    end
  end

  wire [`OFFSET_W-1:0] off_rd_val =
    (off_rsel_r == `SEL_FULL_OFF) ? af_thresh_r : ae_thresh_r;

  ////////////////////////////////////////////////////////////////////////
  // write side

  // array has no reset, only the pointers do
  always @(posedge sys_clk_i) begin
    if (fifo_wr) begin
      mem[wr_ptr_r[ADDR_W-1:0]] <= din_s; // [RULE25]
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_r <= {CW{1'b0}}; // [RULE26]
    end else if (fifo_wr) begin
      wr_ptr_r <= wr_ptr_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read side

  reg [`DATA_W-1:0] dout_r;
  reg               empty_n_r;
  reg               oe_r;

  wire std_rd  = ~fall_through_mode_r & rd_edge & ld_n & ~ren_n & ~rd_empty & empty_n_r; // [RULE4]
  wire ft_pop  = fall_through_mode_r & rd_edge & ld_n & ~ren_n & out_valid_r;
  wire ft_load = fall_through_mode_r & rd_edge & ~rd_empty & (~out_valid_r | ft_pop); // [RULE5]
  wire mem_rd  = std_rd | ft_load;
  wire [CW-1:0] rd_ptr_nxt = mem_rd ? rd_ptr_r + {{(CW-1){1'b0}}, 1'b1} : rd_ptr_r;
  wire          out_valid_nxt = ft_load | (out_valid_r & ~ft_pop);

  // pipeline of the write pointer into the read domain, stepped by read edges
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_vis1_r <= {CW{1'b0}};
      wr_vis2_r <= {CW{1'b0}};
    end else if (rd_edge) begin
      wr_vis1_r <= wr_ptr_r;
      wr_vis2_r <= wr_vis1_r;
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_ptr_r    <= {CW{1'b0}}; // [RULE26]
      out_valid_r <= 1'b0;
    end else begin
      rd_ptr_r    <= rd_ptr_nxt;
      out_valid_r <= fall_through_mode_r & out_valid_nxt; // [RULE7]
    end
  end

  // output register: words, offsets, or hold
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dout_r <= `DOUT_RST; // [RULE26]
    end else if (mem_rd) begin
      dout_r <= mem[rd_ptr_r[ADDR_W-1:0]]; // [RULE1]
    end else if (off_rd) begin
      dout_r <= {{(`DATA_W-`OFFSET_W){1'b0}}, off_rd_val}; // [RULE13]
    end
  end
  // no else branch: with read enable high the word stays unless a fall-through load fills an empty output stage [RULE2]

  // empty flag / output ready, moved on read edges and once at strap capture
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      empty_n_r <= 1'b0;
    end else if (strap_take) begin
      empty_n_r <= wxi_n & ~rxi_n; // standard resets low, fall-through high
    end else if (rd_edge) begin
      if (fall_through_mode_r) begin
        empty_n_r <= ~out_valid_nxt; // [RULE6]
      end else begin
        empty_n_r <= (wr_vis2_r != rd_ptr_nxt); // [RULE4]
      end
    end
  end
  // the edge gate above keeps the flag in the read domain [RULE20]

  // output enable registered so the enable pin is a flop too
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= ~oe_n; // [RULE8]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // full / input ready and almost full

  reg af_n_r;

  wire [`SUM_W-1:0] cap   = fall_through_mode_r ? CAP_FALL_THROUGH_MODE : CAP_STD; // [RULE19]
  // count once this edge's write is in, so the flags move on the filling write itself
  wire [`SUM_W-1:0] total_nxt = total_w + {{(`SUM_W-1){1'b0}}, fifo_wr};
  wire [`SUM_W-1:0] af_sum = total_nxt + {{(`SUM_W-`OFFSET_W){1'b0}}, af_thresh_r};
  wire              af_hit = (af_sum >= cap); // [RULE21] [RULE22]
  wire              is_full = (total_nxt == cap);

  // full flag moves on write edges and once at strap capture
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      full_n_r <= 1'b1;
    end else if (strap_take) begin
      full_n_r <= ~(wxi_n & ~rxi_n); // input ready low means room
    end else if (wr_edge) begin
      if (fall_through_mode_r) begin
        full_n_r <= is_full; // [RULE19] [RULE20]
      end else begin
        full_n_r <= ~is_full; // [RULE18] [RULE20]
      end
    end
  end
  // writes are also gated on the array count, a second guard against overflow

  // almost-full: async asserts on writes and clears on reads
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      af_n_r <= 1'b1;
    end else if (sync_paf_r) begin
      if (wr_edge) begin
        af_n_r <= ~af_hit; // [RULE23]
      end
    end else begin
      if (wr_edge && af_hit) begin
        af_n_r <= 1'b0; // [RULE23]
      end else if (rd_edge && !af_hit) begin
        af_n_r <= 1'b1; // [RULE23]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign data_out_o           = dout_r;
  assign data_out_oe_o        = oe_r;
  assign full_flag_n_o        = full_n_r;
  assign empty_flag_n_o       = empty_n_r;
  assign almost_full_flag_n_o = af_n_r;

endmodule // fifo_read_ctrl

`default_nettype wire

//--- fifo_read_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "fifo_rd_defs.vh"
module fifo_read_ctrl_monitor (
  input wire logic               sys_clk_i,
  input wire logic               nrst_i,
  input wire logic               wr_clk_i,
  input wire logic               rd_clk_i,
  input wire logic               read_enable_n_i,
  input wire logic               offset_load_n_i,
  input wire logic               output_enable_n_i,
  input wire logic               first_load_strap_n_i,
  input wire logic               write_expansion_in_n_i,
  input wire logic               read_expansion_in_n_i,
  input wire logic [`DATA_W-1:0] data_out_o,
  input wire logic               data_out_oe_o,
  input wire logic               full_flag_n_o,
  input wire logic               empty_flag_n_o,
  input wire logic               almost_full_flag_n_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // cycles since each clock pin was seen high; flags may only move soon after one
  logic [3:0] rd_age_r;
  logic [3:0] wr_age_r;
  logic       std_w;
  assign std_w = !(write_expansion_in_n_i && !read_expansion_in_n_i);
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_age_r <= 4'hF;
      wr_age_r <= 4'hF;
    end else begin
      rd_age_r <= rd_clk_i ? 4'h0 : rd_age_r + {3'h0, rd_age_r != 4'hF};
      wr_age_r <= wr_clk_i ? 4'h0 : wr_age_r + {3'h0, wr_age_r != 4'hF};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // six quiet cycles cover the pin sampler delay plus the output flop
  sequence s_no_read;
    (std_w && read_enable_n_i)[*6];
  endsequence
  sequence s_empty_idle;
    (std_w && offset_load_n_i && !empty_flag_n_o)[*6];
  endsequence
  a_reset_values: assert property (
    $rose(nrst_i) |-> data_out_o == `DOUT_RST && full_flag_n_o && almost_full_flag_n_o)
    else $error("outputs wrong after reset");
  a_oe_drives: assert property ((!output_enable_n_i)[*4] |-> data_out_oe_o)
    else $error("output bus not driven");
  a_oe_floats: assert property (output_enable_n_i[*4] |-> !data_out_oe_o)
    else $error("output bus not floated");
  a_hold_no_read: assert property (s_no_read |-> $stable(data_out_o))
    else $error("output word moved without read");
  a_empty_blocks_read: assert property (s_empty_idle |-> $stable(data_out_o))
    else $error("read taken while empty");
  a_empty_on_read: assert property (
    std_w && $changed(empty_flag_n_o) |-> rd_age_r <= 4'h5)
    else $error("empty flag moved without read clock");
  a_full_on_write: assert property (
    std_w && $changed(full_flag_n_o) |-> wr_age_r <= 4'h5)
    else $error("full flag moved without write clock");
  a_af_set_write: assert property ($fell(almost_full_flag_n_o) |-> wr_age_r <= 4'h5)
    else $error("almost full set without write clock");
  a_af_clear_clock: assert property (
    $rose(almost_full_flag_n_o) |-> (first_load_strap_n_i ? wr_age_r : rd_age_r) <= 4'h5)
    else $error("almost full cleared on wrong clock");
endmodule // fifo_read_ctrl_monitor

bind fifo_read_ctrl fifo_read_ctrl_monitor mon_u (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .wr_clk_i(wr_clk_i), .rd_clk_i(rd_clk_i),
  .read_enable_n_i(read_enable_n_i), .offset_load_n_i(offset_load_n_i),
  .output_enable_n_i(output_enable_n_i), .first_load_strap_n_i(first_load_strap_n_i),
  .write_expansion_in_n_i(write_expansion_in_n_i),
  .read_expansion_in_n_i(read_expansion_in_n_i), .data_out_o(data_out_o),
  .data_out_oe_o(data_out_oe_o), .full_flag_n_o(full_flag_n_o),
  .empty_flag_n_o(empty_flag_n_o), .almost_full_flag_n_o(almost_full_flag_n_o));
`default_nettype wire

//--- fifo_ext_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "fifo_rd_defs.vh"
module fifo_ext_logic (
  input  wire logic               sys_clk_i,
  output var  logic               wr_clk_o,
  output var  logic               rd_clk_o,
  output var  logic               write_enable_n_o,
  output var  logic               read_enable_n_o,
  output var  logic               offset_load_n_o,
  output var  logic [`DATA_W-1:0] data_o
);
  // idle pins at time zero
  initial begin
    wr_clk_o = 1'b0;
    rd_clk_o = 1'b0;
    write_enable_n_o = 1'b1;
    read_enable_n_o = 1'b1;
    offset_load_n_o = 1'b1;
    data_o = 18'h00000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // clock pins stand still between cycles; each level lasts 4 system clocks so the
  // pin sampler sees it; calls never overlap, so offsets are not read and written at once
  task automatic pin_cycle(input logic is_wr);
    repeat (2) @(posedge sys_clk_i);
    #1;
    wr_clk_o = is_wr;
    rd_clk_o = !is_wr;
    repeat (4) @(posedge sys_clk_i);
    #1;
    wr_clk_o = 1'b0;
    rd_clk_o = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    write_enable_n_o = 1'b1;
    read_enable_n_o = 1'b1;
    offset_load_n_o = 1'b1;
  endtask
  task automatic wr_cycle(input logic ld_n, input logic wen_n, input logic [`DATA_W-1:0] d);
    @(posedge sys_clk_i);
    #1;
    offset_load_n_o = ld_n;
    write_enable_n_o = wen_n;
    data_o = d;
    pin_cycle(1'b1);
    // released data lines must not keep showing the old word
    data_o = ~d;
  endtask
  task automatic rd_cycle(input logic ld_n, input logic ren_n);
    @(posedge sys_clk_i);
    #1;
    offset_load_n_o = ld_n;
    read_enable_n_o = ren_n;
    pin_cycle(1'b0);
  endtask
endmodule // fifo_ext_logic
`default_nettype wire

//--- dual_clock_fifo_read_flags_offsets_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fifo_rd_defs.vh"
module dual_clock_fifo_read_flags_offsets_tb;
  localparam int DEPTH = 16;
  localparam logic [`DATA_W-1:0] HI = 18'h00001;
  localparam logic [`DATA_W-1:0] LO = 18'h00000;
  logic               sys_clk_i;
  logic               nrst_i;
  logic               oe_n;
  logic               fl_n;
  logic               wxi_n;
  logic               rxi_n;
  wire                wr_clk;
  wire                rd_clk;
  wire                wen_n;
  wire                ren_n;
  wire                ld_n;
  wire  [`DATA_W-1:0] din;
  wire  [`DATA_W-1:0] dout;
  wire                oe;
  wire                full_n;
  wire                empty_n;
  wire                af_n;
  int                 bad_count;
  int                 samples_checked;
  int                 cyc = 0;
  fifo_ext_logic ext_u (.sys_clk_i(sys_clk_i), .wr_clk_o(wr_clk), .rd_clk_o(rd_clk),
    .write_enable_n_o(wen_n), .read_enable_n_o(ren_n), .offset_load_n_o(ld_n), .data_o(din));
  fifo_read_ctrl #(.DEPTH(DEPTH), .ADDR_W(4), .OFF_DEF(12'h003)) dut_u (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .wr_clk_i(wr_clk), .rd_clk_i(rd_clk),
    .write_enable_n_i(wen_n), .read_enable_n_i(ren_n), .offset_load_n_i(ld_n),
    .output_enable_n_i(oe_n), .first_load_strap_n_i(fl_n), .write_expansion_in_n_i(wxi_n),
    .read_expansion_in_n_i(rxi_n), .data_in_i(din), .data_out_o(dout), .data_out_oe_o(oe),
    .full_flag_n_o(full_n), .empty_flag_n_o(empty_n), .almost_full_flag_n_o(af_n));
  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz system clock
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input string nm, input logic [`DATA_W-1:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // straps must stay put well past release, since they are taken after it
  task automatic do_reset(input logic fl, input logic write_expansion_in_n, input logic read_expansion_in_n);
    @(posedge sys_clk_i);
    #1;
    nrst_i = 1'b0;
    fl_n = fl;
    wxi_n = write_expansion_in_n;
    rxi_n = read_expansion_in_n;
    repeat (8) @(posedge sys_clk_i);
    #1;
    nrst_i = 1'b1;
    repeat (8) @(posedge sys_clk_i);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // offset programming with a no-op write and wrap, then output enable
  task automatic t_offsets;
    check("dout_rst", dout, LO);
    check("empty_rst", empty_n, LO);
    check("full_rst", full_n, HI);
    ext_u.wr_cycle(1'b0, 1'b0, 18'h00002);
    ext_u.wr_cycle(1'b0, 1'b0, 18'h00004);
    ext_u.wr_cycle(1'b0, 1'b1, 18'h00007);
    ext_u.wr_cycle(1'b0, 1'b0, 18'h00006);
    ext_u.rd_cycle(1'b0, 1'b0);
    check("off_wrap", dout, 18'h00006);
    ext_u.rd_cycle(1'b0, 1'b0);
    check("off_full", dout, 18'h00004);
    ext_u.rd_cycle(1'b0, 1'b0);
    check("off_rd_wrap", dout, 18'h00006);
    oe_n = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1;
    check("oe_off", oe, LO);
    oe_n = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    #1;
    check("oe_on", oe, HI);
  endtask
  // standard mode: fill past depth with m = 4, then drain every word by request
  task automatic t_fill;
    for (int i = 0; i <= DEPTH; i++) begin
      ext_u.wr_cycle(1'b1, 1'b0, 18'h00100 + i[17:0]);
      if (i == 10) check("af_below", af_n, HI);
      if (i == 11) check("af_exact", af_n, LO);
      if (i == 12) check("af_at", af_n, LO);
      if (i == DEPTH - 2) check("room_std", full_n, HI);
      if (i == DEPTH - 1) check("full_exact", full_n, LO);
    end
    check("full_at_depth", full_n, LO);
    // the empty flag needs three read edges to see the writes through the pointer pipe
    repeat (3) ext_u.rd_cycle(1'b1, 1'b1);
    check("hold_no_read", dout, 18'h00006);
    check("not_empty", empty_n, HI);
    for (int i = 0; i < DEPTH; i++) begin
      ext_u.rd_cycle(1'b1, 1'b0);
      check("read_word", dout, 18'h00100 + i[17:0]);
    end
    check("empty_last", empty_n, LO);
    check("af_cleared", af_n, HI);
    ext_u.rd_cycle(1'b1, 1'b0);
    check("read_while_empty", dout, 18'h0010F);
  endtask
  // fall-through mode: first word appears unrequested, capacity is depth plus one
  task automatic t_fall_through_mode;
    check("ready_rst", empty_n, HI);
    check("room_rst", full_n, LO);
    ext_u.wr_cycle(1'b1, 1'b0, 18'h2AAAA);
    ext_u.rd_cycle(1'b1, 1'b1);
    ext_u.rd_cycle(1'b1, 1'b1);
    check("not_yet", dout, LO);
    ext_u.rd_cycle(1'b1, 1'b1);
    check("fall_through", dout, 18'h2AAAA);
    check("ready_low", empty_n, LO);
    ext_u.rd_cycle(1'b0, 1'b0);
    check("no_off_read", dout, 18'h2AAAA);
    ext_u.rd_cycle(1'b1, 1'b0);
    check("ready_high", empty_n, HI);
    check("last_kept", dout, 18'h2AAAA);
    for (int i = 0; i <= DEPTH + 1; i++) begin
      ext_u.wr_cycle(1'b1, 1'b0, i[17:0]);
      if (i == 0) begin
        // read clock is stopped otherwise; three edges move this word to the output stage
        repeat (3) ext_u.rd_cycle(1'b1, 1'b1);
        check("second_fall", dout, LO);
        check("ready_again", empty_n, LO);
      end
      if (i == 12) check("af_fall_through_mode_hi", af_n, HI);
      if (i == 13) check("af_fall_through_mode_at", af_n, LO);
      if (i == DEPTH - 1) check("room_left", full_n, LO);
      if (i == DEPTH) check("room_gone", full_n, HI);
    end
    check("af_fall_through_mode_lo", af_n, LO);
    check("no_room", full_n, HI);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence; single-device straps, asynchronous partial flags first
  initial begin
    nrst_i = 1'b0;
    oe_n = 1'b0;
    fl_n = 1'b0;
    wxi_n = 1'b0;
    rxi_n = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    do_reset(1'b0, 1'b0, 1'b0);
    t_offsets();
    t_fill();
    do_reset(1'b1, 1'b1, 1'b0);
    t_fall_through_mode();
    tally_and_finish();
  end
  // runaway guard: the run needs about 825 system clocks
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
endmodule // dual_clock_fifo_read_flags_offsets_tb
`default_nettype wire
